// ==== bench/dmdc_dram_model.sv ====
// Behavioural DRAM planes standing at the controller's memory pins
`timescale 1ns/10ps
`default_nettype none
module dmdc_dram_model
  import dmdc_pkg::*;
(
  input  wire logic                 clk,
  input  wire dmdc_dram_t           dram,
  output logic [DATA_BITS-1:0]      rdata,
  output var int                    cbr_cnt
);
  logic [7:0]           mem [PLANES][65536];
  logic [7:0]           row [2];
  logic [7:0]           col [2];
  logic                 ras_q = 1'b1;
  logic [DATA_BITS-1:0] last = '0;
  int                   cbr_q = 0;
  assign cbr_cnt = cbr_q;
  // planes 0/1 on the low bus, 2/3 on the high bus
  assign col[0] = dram.addr_lo;
  assign col[1] = dram.addr_hi;
  initial
  begin
    for (int p = 0; p < PLANES; p++)
      for (int a = 0; a < 65536; a++)
        mem[p][a] = 8'h00;
  end
  // data stands only while RAS and the plane's CAS are low
  // Released lanes show the inverse of their last value, never a hold
  always @*
    for (int p = 0; p < PLANES; p++)
      if (!dram.ras_n && !dram.cas_n[p] && dram.we_n)
        rdata[p*8 +: 8] = mem[p][{row[p/2], col[p/2]}];
      else
        rdata[p*8 +: 8] = ~last[p*8 +: 8];
  always @(posedge clk)
  begin
    last  <= rdata;
    ras_q <= dram.ras_n;
    if (ras_q && !dram.ras_n)
    begin
      row[0] <= dram.addr_lo;
      row[1] <= dram.addr_hi;
      // all CAS already low as RAS falls marks a refresh
      if (dram.cas_n == '0)
        cbr_q <= cbr_q + 1;
    end
    // a plane stores only under its own CAS and the shared WE
    for (int p = 0; p < PLANES; p++)
      if (!dram.ras_n && !dram.cas_n[p] && !dram.we_n)
        mem[p][{row[p/2], col[p/2]}] <= dram.wdata[p*8 +: 8];
  end
endmodule // dmdc_dram_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the display memory DRAM controller
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import dmdc_pkg::*;
;
  typedef struct packed {
    logic [1:0]  kind;
    logic        is16;
    logic [19:0] addr;
    logic [15:0] wd;
    logic [15:0] exp;
    logic        cmp;
  } dmdc_row_t;
  // Kinds: 0 memory write, 1 memory read, 2 I/O write, 3 I/O read
  localparam dmdc_row_t ROWS [10] = '{
    '{2'h0, 1'h0, 20'hA_0000, 16'h0011, 16'h0000, 1'h0},
    '{2'h0, 1'h0, 20'hA_0001, 16'h0022, 16'h0000, 1'h0},
    '{2'h0, 1'h0, 20'hA_0002, 16'h0033, 16'h0000, 1'h0},
    '{2'h0, 1'h0, 20'hA_0003, 16'h0044, 16'h0000, 1'h0},
    '{2'h1, 1'h1, 20'hA_0000, 16'h0000, 16'h2211, 1'h1},
    '{2'h1, 1'h1, 20'hA_0002, 16'h0000, 16'h4433, 1'h1},
    '{2'h0, 1'h1, 20'hB_FFFC, 16'h5AA5, 16'h0000, 1'h0},
    '{2'h1, 1'h1, 20'hB_FFFC, 16'h0000, 16'h5AA5, 1'h1},
    '{2'h2, 1'h0, 20'h0_03C4, 16'h0001, 16'h0000, 1'h0},
    '{2'h3, 1'h0, 20'h0_03FF, 16'h0000, 16'h0000, 1'h0}};
  logic                 clk = 1'b0;
  logic                 reset = 1'b1;
  dmdc_host_req_t       host_req = '0;
  logic [7:0]           lin_cfg = '0;
  logic [7:0]           out_sel = '0;
  logic                 text_mode = 1'b0;
  logic                 disp_req = 1'b0;
  logic [DATA_BITS-1:0] rdata;
  logic [DATA_BITS-1:0] ddata;
  dmdc_dram_t           dram;
  logic [15:0]          hrd;
  logic [15:0]          hval;
  logic                 hrdy, dack, act, got;
  logic                 ras_q = 1'b1, act_q = 1'b0;
  logic [1:0]           btype;
  int mismatches = 0, n_checks = 0, cbr_cnt, cbr, cyc = 0;
  int efall, rfall, ahi, alo;
  always #10 clk = ~clk;
  dmdc_ctrl u_dmdc_ctrl (
    .clk(clk), .reset(reset), .strap_bus_type(2'h0),
    .host_req(host_req), .linear_mode_config_reg(lin_cfg),
    .output_select_reg(out_sel), .text_mode(text_mode),
    .disp_req(disp_req), .disp_addr(16'h8000), .dram_rdata(rdata),
    .dram_r(dram), .host_rdata_r(hrd), .host_ready_r(hrdy),
    .disp_data_r(ddata), .disp_ack_r(dack), .bus_type_r(btype),
    .cpu_activity_out_r(act));
  dmdc_dram_model u_dmdc_dram_model (
    .clk(clk), .dram(dram), .rdata(rdata), .cbr_cnt(cbr_cnt));
  // Edge-by-edge watch of the activity pin and the row strobe
  always @(posedge clk)
  begin
    cyc++;
    if (act === 1'b1) ahi++;
    if (act === 1'b0) alo++;
    if (act_q === 1'b1 && act === 1'b0 && efall < 0) efall = cyc;
    if (ras_q === 1'b1 && dram.ras_n === 1'b0 && efall >= 0 && rfall < 0)
      rfall = cyc;
    act_q = act;
    ras_q = dram.ras_n;
  end
  task automatic end_of_test;
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  // A wait that ran out ends the run at once
  task automatic need(input logic ok, input string msg);
    chk(ok, msg);
    if (ok !== 1'b1) end_of_test;
  endtask
  // Clear the watch off the sampling edge to avoid a race with it
  task automatic mclr;
    @(negedge clk);
    efall = -1;
    rfall = -1;
    ahi = 0;
    alo = 0;
  endtask
  // Request held until ready is sampled high, then released
  task automatic host(input dmdc_row_t r, input int lim);
    dmdc_host_req_t q;
    q = '0;
    q.mem_wr = (r.kind == 2'h0);
    q.mem_rd = (r.kind == 2'h1);
    q.io_wr = (r.kind == 2'h2);
    q.io_rd = (r.kind == 2'h3);
    q.is16 = r.is16;
    q.addr = r.addr;
    q.wdata = r.wd;
    got = 1'b0;
    mclr;
    @(posedge clk);
    host_req <= q;
    for (int n = 0; n < lim && !got; n++)
    begin
      @(posedge clk);
      got = (hrdy === 1'b1);
      hval = hrd;
    end
    host_req <= '0;
    // Let the watch count the edge at which ready was seen
    @(negedge clk);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    chk(dram.ras_n === 1'b1 && dram.cas_n === 4'hF && dram.we_n === 1'b1
        && hrdy === 1'b0, "reset levels");
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk(btype === 2'h0, "bus type strap");
    foreach (ROWS[i])
    begin
      host(ROWS[i], 40);
      need(got, "no ready");
      chk(!ROWS[i].cmp || hval === ROWS[i].exp, "read data");
      chk(ahi > 0, "activity missing");
    end
    host('{2'h1, 1'h0, 20'hC_0000, 16'h0000, 16'h0000, 1'h0}, 40);
    chk(got === 1'b0 && ahi == 0, "stray decode");
    lin_cfg[LIN_BIT] <= 1'b1;
    host('{2'h1, 1'h0, 20'hC_0000, 16'h0000, 16'h0000, 1'h0}, 40);
    need(got, "linear window");
    host('{2'h1, 1'h0, 20'h8_0000, 16'h0000, 16'h0000, 1'h0}, 40);
    need(got, "A19 window");
    lin_cfg <= 8'h00;
    out_sel[EARLY_EN_BIT] <= 1'b1;
    text_mode <= 1'b1;
    host('{2'h0, 1'h1, 20'hA_0010, 16'h1234, 16'h0000, 1'h0}, 60);
    need(got, "text write");
    chk(efall >= 0 && rfall - efall == int'(T_EARLY), "early lead");
    chk(act === 1'b1, "early enable idle");
    mclr;
    @(posedge clk);
    disp_req <= 1'b1;
    got = 1'b0;
    for (int n = 0; n < 60 && !got; n++)
    begin
      @(posedge clk);
      got = (dack === 1'b1);
    end
    disp_req <= 1'b0;
    need(got, "display fetch");
    chk(ddata === 32'h4433_2211, "fetch data");
    chk(alo == 0, "enable on fetch");
    text_mode <= 1'b0;
    host('{2'h0, 1'h0, 20'hA_0020, 16'h0055, 16'h0000, 1'h0}, 60);
    need(got, "graphics write");
    chk(alo == 0, "enable in graphics");
    cbr = cbr_cnt;
    for (int n = 0; n < 2 * REFRESH_INTERVAL && cbr_cnt == cbr; n++)
      @(posedge clk);
    need(cbr_cnt > cbr, "refresh");
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire

// ==== shared/dmdc_pkg.sv ====
// Shared constants and types for the display memory DRAM controller
package dmdc_pkg;
  localparam int PLANES       = 4;
  localparam int PLANE_BITS   = 8;
  localparam int DATA_BITS    = PLANES * PLANE_BITS;
  localparam int PLANE_AW     = 16;
  localparam int DRAM_AW      = 8;
  localparam int HOST_AW      = 20;
  localparam int LIN_BIT      = 6;
  localparam int EARLY_EN_BIT = 3;
  localparam int A19_BIT      = 19;
  localparam logic [3:0] T_EARLY    = 4'h2;
  localparam logic [3:0] T_RAS      = 4'h3;
  localparam logic [3:0] T_CAS      = 4'h2;
  localparam logic [3:0] T_PRE      = 4'h2;
  localparam logic [9:0] REFRESH_INTERVAL = 10'h0180;
  localparam logic [HOST_AW-1:0] VGA_BASE = 20'hA_0000;
  localparam logic [HOST_AW-1:0] VGA_MASK = 20'hE_0000;
  localparam logic [15:0] IO_BASE  = 16'h03C0;
  localparam logic [15:0] IO_MASK  = 16'hFFC0;

  typedef enum logic [1:0] {DMDC_SRC_NONE, DMDC_SRC_REF, DMDC_SRC_DISP,
                            DMDC_SRC_CPU} dmdc_src_t;

  typedef struct packed {
    logic                 mem_rd;
    logic                 mem_wr;
    logic                 io_rd;
    logic                 io_wr;
    logic                 is16;
    logic [HOST_AW-1:0]   addr;
    logic [15:0]          wdata;
  } dmdc_host_req_t;

  typedef struct packed {
    logic [DRAM_AW-1:0]   addr_lo;
    logic [DRAM_AW-1:0]   addr_hi;
    logic                 ras_n;
    logic [PLANES-1:0]    cas_n;
    logic                 we_n;
    logic [DATA_BITS-1:0] wdata;
    logic                 wdata_oe;
  } dmdc_dram_t;
endpackage

// ==== verilog/dmdc_ctrl.sv ====
// Display memory DRAM controller: arbitration, timing and host decode
// Notes on behaviour
// - Memory is four byte-wide planes of 64 KB forming a 32-bit path.
// - Planes 0 and 1 share one address bus, planes 2 and 3 another.
// - Each plane has its own CAS, all share one RAS and one WE.
// - Refresh, screen fetch and CPU accesses are arbitrated here.
// - Refresh uses CAS-before-RAS cycles.
// - All DRAM timing is counted on the memory clock.
// - The host bus type comes from straps caught after reset.
// - 8-bit and 16-bit memory cycles are width translated; I/O cycles are only acknowledged.
// - All memory and I/O addresses are decoded internally.
// - Linear bit 6 qualifies chip select by reads/writes for 1 MB.
// - On ISA, the activity output goes high on valid VGA accesses.
// - On ISA, output select bit 3 turns the activity pin into early enable.
// - Early enable falls two clocks before RAS and holds until RAS.
// - Early enable stays high in graphics and on display fetches.
`timescale 1ns/10ps
`default_nettype none
module dmdc_ctrl
  import dmdc_pkg::*;
#(
  parameter int STRAP_W = 2
)(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [STRAP_W-1:0]   strap_bus_type,
  input  wire dmdc_host_req_t       host_req,
  input  wire logic [7:0]           linear_mode_config_reg,
  input  wire logic [7:0]           output_select_reg,
  input  wire logic                 text_mode,
  input  wire logic                 disp_req,
  input  wire logic [PLANE_AW-1:0]  disp_addr,
  input  wire logic [DATA_BITS-1:0] dram_rdata,
  output dmdc_dram_t                dram_r,
  output logic [15:0]               host_rdata_r,
  output logic                      host_ready_r,
  output logic [DATA_BITS-1:0]      disp_data_r,
  output logic                      disp_ack_r,
  output logic [STRAP_W-1:0]        bus_type_r,
  output logic                      cpu_activity_out_r
);
  typedef enum {S_IDLE, S_EARLY, S_ROW, S_COL, S_PRE,
                S_CBR_CAS, S_CBR_RAS} dmdc_state_t;

  dmdc_state_t          state_r;
  dmdc_state_t          state_nxt;
  dmdc_src_t            src_r;
  logic [3:0]           cnt_r;
  logic [9:0]           ref_cnt_r;
  logic                 ref_pend_r;
  logic                 strap_taken_r;
  logic                 cpu_busy_r;
  dmdc_host_req_t       req_r;
  logic                 early_en_n_r;

  // Address decode
  wire logic mem_cyc   = host_req.mem_rd | host_req.mem_wr;
  wire logic io_cyc    = host_req.io_rd | host_req.io_wr;
  wire logic lin_en    = linear_mode_config_reg[LIN_BIT];
  wire logic vga_mem   = (host_req.addr & VGA_MASK) == VGA_BASE;
  wire logic lin_hit   = lin_en & mem_cyc;
  wire logic mem_hit   = mem_cyc & (vga_mem | lin_hit);
  wire logic io_hit    = io_cyc & ((host_req.addr[15:0] & IO_MASK) == IO_BASE);
  wire logic cpu_hit   = (mem_hit | io_hit) & ~cpu_busy_r & ~host_ready_r;
  wire logic is_isa    = bus_type_r == '0;
  wire logic early_sel = output_select_reg[EARLY_EN_BIT];
  wire logic ref_due   = ref_cnt_r == REFRESH_INTERVAL;

  // Arbiter: refresh first, then screen fetch, then CPU
  // arbitration priority
  wire logic start_ref  = (state_r == S_IDLE) & ref_pend_r;
  wire logic start_disp = (state_r == S_IDLE) & ~ref_pend_r & disp_req;
  wire logic start_cpu  = (state_r == S_IDLE) & ~ref_pend_r & ~disp_req &
                          cpu_busy_r & (req_r.mem_rd | req_r.mem_wr);
  // Source of the slot being launched now; src_r lags by one clock
  wire dmdc_src_t src_cur = start_ref  ? DMDC_SRC_REF :
                            start_disp ? DMDC_SRC_DISP :
                            start_cpu  ? DMDC_SRC_CPU : src_r;

  // plane and lane selection for width translation
  wire logic [1:0] plane_sel = req_r.addr[1:0];
  wire logic [PLANE_AW-1:0] cpu_word = req_r.addr[PLANE_AW+1:2];
  wire logic [PLANE_AW-1:0] row_col_src =
    (src_cur == DMDC_SRC_DISP) ? disp_addr : cpu_word;
  logic [PLANES-1:0] cas_mask;
  always_comb
  begin
    cas_mask = '0;
    if (src_cur == DMDC_SRC_DISP || src_cur == DMDC_SRC_REF)
      cas_mask = '1;
    else
    begin
      cas_mask[plane_sel] = 1'b1;
      if (req_r.is16)
        cas_mask[plane_sel | 2'h1] = 1'b1;
    end
  end

  wire logic cnt_done   = cnt_r == 4'h1;
  wire logic cpu_text   = start_cpu & text_mode;

  // every transition out of a state other than S_IDLE is counted in memory clocks
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE:
        if (start_ref)
          state_nxt = S_CBR_CAS;
        else if (cpu_text)
          state_nxt = S_EARLY;
        else if (start_disp | start_cpu)
          state_nxt = S_ROW;
      S_EARLY:   if (cnt_done) state_nxt = S_ROW;
      S_ROW:     if (cnt_done) state_nxt = S_COL;
      S_COL:     if (cnt_done) state_nxt = S_PRE;
      S_CBR_CAS: if (cnt_done) state_nxt = S_CBR_RAS;
      S_CBR_RAS: if (cnt_done) state_nxt = S_PRE;
      S_PRE:     if (cnt_done) state_nxt = S_IDLE;
    endcase
  end

  wire logic [3:0] cnt_load =
    (state_nxt == S_EARLY) ? T_EARLY :
    (state_nxt == S_ROW)   ? T_RAS :
    (state_nxt == S_COL || state_nxt == S_CBR_CAS) ? T_CAS :
    (state_nxt == S_CBR_RAS) ? T_RAS : T_PRE;
  wire logic [3:0] cnt_nxt = (state_nxt != state_r) ? cnt_load :
                             (cnt_r - 4'h1);
  wire logic ras_on = state_nxt == S_ROW || state_nxt == S_COL ||
                      state_nxt == S_CBR_RAS;
  wire logic cas_on = state_nxt == S_COL || state_nxt == S_CBR_CAS ||
                      state_nxt == S_CBR_RAS;
  wire logic cpu_wr = src_cur == DMDC_SRC_CPU && req_r.mem_wr;
  wire logic cyc_end = state_r == S_COL && cnt_done;
  wire logic io_done = cpu_busy_r & ~req_r.mem_rd & ~req_r.mem_wr;
  wire logic [15:0] rd_lane = plane_sel[1] ? dram_rdata[31:16] :
                              dram_rdata[15:0];
  wire logic [15:0] rd_host = req_r.is16 ? rd_lane :
    {8'h00, dram_rdata[plane_sel*PLANE_BITS +: PLANE_BITS]};
  wire logic [PLANE_BITS-1:0] wr_byte = req_r.wdata[7:0];
  wire logic [15:0] wr_lane = req_r.is16 ? req_r.wdata : {wr_byte, wr_byte};
  // early enable low from two clocks before RAS until RAS
  // only CPU text accesses lower it
  wire logic early_en_nxt = ~(state_nxt == S_EARLY);

  always_ff @(posedge clk)
    if (reset)
    begin
      state_r <= S_IDLE;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end

  always_ff @(posedge clk)
    if (reset)
      src_r <= DMDC_SRC_NONE;
    else if (start_ref)
      src_r <= DMDC_SRC_REF;
    else if (start_disp)
      src_r <= DMDC_SRC_DISP;
    else if (start_cpu)
      src_r <= DMDC_SRC_CPU;

  // Refresh timer; a new request wins over the clear of the pending flag
  always_ff @(posedge clk)
    if (reset)
    begin
      ref_cnt_r  <= '0;
      ref_pend_r <= 1'b0;
    end
    else
    begin
      ref_cnt_r  <= ref_due ? '0 : ref_cnt_r + 10'h001;
      ref_pend_r <= ref_due | (ref_pend_r & ~start_ref);
    end

  // straps caught on the first clock after reset release
  always_ff @(posedge clk)
    if (reset)
    begin
      strap_taken_r <= 1'b0;
      bus_type_r    <= '0;
    end
    else if (!strap_taken_r)
    begin
      strap_taken_r <= 1'b1;
      bus_type_r    <= strap_bus_type;
    end

  // Host request latch; holds a memory cycle until its DRAM slot completes, an I/O cycle for one clock
  always_ff @(posedge clk)
    if (reset)
    begin
      cpu_busy_r <= 1'b0;
      req_r      <= '0;
    end
    else if (cpu_hit)
    begin
      cpu_busy_r <= 1'b1;
      req_r      <= host_req;
    end
    else if ((cyc_end && src_r == DMDC_SRC_CPU) || io_done)
      cpu_busy_r <= 1'b0;

  always_ff @(posedge clk)
    if (reset)
    begin
      host_ready_r <= 1'b0;
      host_rdata_r <= '0;
    end
    else
    begin
      host_ready_r <= (cyc_end && src_r == DMDC_SRC_CPU) || io_done;
      if (cyc_end && src_r == DMDC_SRC_CPU && req_r.mem_rd)
        host_rdata_r <= rd_host;
    end

  always_ff @(posedge clk)
    if (reset)
    begin
      disp_ack_r  <= 1'b0;
      disp_data_r <= '0;
    end
    else
    begin
      disp_ack_r <= cyc_end && src_r == DMDC_SRC_DISP;
      if (cyc_end && src_r == DMDC_SRC_DISP)
        disp_data_r <= dram_rdata;
    end

  always_ff @(posedge clk)
    if (reset)
      dram_r <= '{addr_lo: '0, addr_hi: '0, ras_n: 1'b1, cas_n: '1,
                  we_n: 1'b1, wdata: '0, wdata_oe: 1'b0};
    else
    begin
      dram_r.addr_lo  <= (state_nxt == S_ROW) ?
                         row_col_src[PLANE_AW-1:DRAM_AW] :
                         row_col_src[DRAM_AW-1:0];
      dram_r.addr_hi  <= (state_nxt == S_ROW) ?
                         row_col_src[PLANE_AW-1:DRAM_AW] :
                         row_col_src[DRAM_AW-1:0];
      dram_r.ras_n    <= ~ras_on;
      dram_r.cas_n    <= cas_on ? ~cas_mask : '1;
      dram_r.we_n     <= ~(cpu_wr && state_nxt == S_COL);
      dram_r.wdata    <= {wr_lane, wr_lane};
      dram_r.wdata_oe <= cpu_wr && (state_nxt == S_ROW ||
                                    state_nxt == S_COL);
    end

  // activity pin or early enable, ISA only
  always_ff @(posedge clk)
    if (reset)
    begin
      early_en_n_r       <= 1'b1;
      cpu_activity_out_r <= 1'b0;
    end
    else
    begin
      early_en_n_r <= early_en_nxt;
      if (is_isa && early_sel)
        cpu_activity_out_r <= early_en_nxt;
      else
        cpu_activity_out_r <= is_isa & cpu_hit;
    end

  // Assertions
  a_early_before_ras: assert property (@(posedge clk) disable iff (reset)
    $fell(early_en_n_r) |=> early_en_n_r == 1'b0 ##1 $fell(dram_r.ras_n))
    else $error("early enable not two clocks before RAS");
  a_no_early_graph: assert property (@(posedge clk) disable iff (reset)
    !text_mode && state_r == S_IDLE |=> early_en_n_r)
    else $error("early enable low outside text access");
  a_cbr_order: assert property (@(posedge clk) disable iff (reset)
    state_r == S_CBR_RAS |-> dram_r.cas_n == '0)
    else $error("CAS not low before RAS in refresh");
  a_refresh_served: assert property (@(posedge clk) disable iff (reset)
    $rose(ref_pend_r) |-> ##[1:20] state_r == S_CBR_CAS)
    else $error("refresh not started");
  a_activity_pulse: assert property (@(posedge clk) disable iff (reset)
    is_isa && !early_sel && cpu_hit |=> cpu_activity_out_r)
    else $error("activity not raised");
  a_strap_hold: assert property (@(posedge clk) disable iff (reset)
    strap_taken_r && $past(strap_taken_r) |-> $stable(bus_type_r))
    else $error("bus type changed after strap capture");
  a_we_shared: assert property (@(posedge clk) disable iff (reset)
    !dram_r.we_n |-> !dram_r.ras_n)
    else $error("write enable outside row cycle");
  a_ras_width: assert property (@(posedge clk) disable iff (reset)
    $fell(dram_r.ras_n) |-> !dram_r.ras_n [*2])
    else $error("RAS pulse too short");
endmodule // dmdc_ctrl
`default_nettype wire
